// *** rtl/scope_io_regs.v ***
// Host I/O register block of a two-channel scope card: eight byte ports,
// indexed write-only data registers, trigger logic and sample read path.
// Assumes the host strobes arrive asynchronously and the converter samples
// and memory bytes are stable around each sample clock enable.
`include "scope_io_defs.vh"

module scope_io_regs #(
  parameter BASE_SW_W = 7
) (
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire                   ce,
  input  wire [9:0]             host_addr,
  input  wire [7:0]             host_wdata,
  input  wire                   host_iow_n,
  input  wire                   host_ior_n,
  input  wire [BASE_SW_W-1:0]   base_select_switch,
  input  wire [7:0]             adc_one_data,
  input  wire [7:0]             adc_two_data,
  input  wire [7:0]             mem_one_data,
  input  wire [7:0]             mem_two_data,
  input  wire                   conv_ready,
  input  wire                   ext_trigger,
  input  wire                   sample_tick,
  output reg  [7:0]             host_rdata,
  output reg                    host_rdata_oe,
  output reg                    sample_clk_run,
  output reg                    sample_clk_internal,
  output reg                    live_data_path,
  output reg                    conv_clk_on,
  output reg  [7:0]             timer_data,
  output reg                    timer_write,
  output reg  [7:0]             timebase_ctrl,
  output reg  [7:0]             mem_one_wdata,
  output reg  [7:0]             mem_two_wdata,
  output reg  [`ADDR_CNT_W-1:0] mem_addr,
  output reg                    measure_active,
  output reg                    trigger_out,
  output reg  [6:0]             serial_one_pins,
  output reg  [6:0]             serial_two_pins,
  output reg                    conv_one_clk_inv,
  output reg                    conv_two_clk_inv
);

  // ========================================================================
  // Pin synchronisers, three stages; a change counts when 2 and 3 agree
  reg  [2:0] iow_s_q;
  reg  [2:0] ior_s_q;
  reg  [2:0] ext_s_q;
  reg        iow_lvl_q;
  reg        ior_lvl_q;
  reg        ext_lvl_q;
  reg        iow_prev_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iow_s_q   <= 3'h7;
      ior_s_q   <= 3'h7;
      ext_s_q   <= 3'h0;
      iow_lvl_q <= 1'b1;
      ior_lvl_q <= 1'b1;
      ext_lvl_q <= 1'b0;
    end else if (ce) begin
      iow_s_q <= {iow_s_q[1:0], host_iow_n};
      ior_s_q <= {ior_s_q[1:0], host_ior_n};
      ext_s_q <= {ext_s_q[1:0], ext_trigger};
      if (iow_s_q[1] == iow_s_q[2]) iow_lvl_q <= iow_s_q[2];
      if (ior_s_q[1] == ior_s_q[2]) ior_lvl_q <= ior_s_q[2];
      if (ext_s_q[1] == ext_s_q[2]) ext_lvl_q <= ext_s_q[2];
    end
  end

  // ========================================================================
  // Address decode; switches hold address lines 9..3
  wire       card_hit  = (host_addr[9:3] == base_select_switch);
  wire [2:0] port_ofs  = host_addr[2:0];

  // One write pulse per strobe fall so a long access steps only once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iow_prev_q <= 1'b1;
    end else if (ce) begin
      iow_prev_q <= iow_lvl_q;
    end
  end

  wire wr_pulse = ce && iow_prev_q && !iow_lvl_q && card_hit;
  wire rd_level = !ior_lvl_q && card_hit;

  // ========================================================================
  // Index (control) registers; a data write goes to what the index picks
  reg [7:0] ctrl_one_q;
  reg [7:0] ctrl_chan_q [0:1];

  wire wr_ctrl1 = wr_pulse && (port_ofs == `OFS_CTRL1);
  wire wr_data1 = wr_pulse && (port_ofs == `OFS_DATA1);
  wire wr_ctrl2 = wr_pulse && (port_ofs == `OFS_CTRL2);
  wire wr_data2 = wr_pulse && (port_ofs == `OFS_DATA2);
  wire wr_ctrl3 = wr_pulse && (port_ofs == `OFS_CTRL3);
  wire wr_data3 = wr_pulse && (port_ofs == `OFS_DATA3);

  // Selected index decode, used for every data port
  function sel;
    input [7:0] ctrl;
    input [2:0] idx;
    begin
      sel = (ctrl[2:0] == idx);
    end
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_one_q     <= `BYTE_RESET;
      ctrl_chan_q[0] <= `BYTE_RESET;
      ctrl_chan_q[1] <= `BYTE_RESET;
    end else begin
      if (wr_ctrl1) ctrl_one_q     <= host_wdata;
      if (wr_ctrl2) ctrl_chan_q[0] <= host_wdata;
      if (wr_ctrl3) ctrl_chan_q[1] <= host_wdata;
    end
  end

  // ========================================================================
  // First control register data registers
  reg [7:0]  acq_setup_q;
  reg [2:0]  trig_src_q;
  reg [15:0] post_target_q;
  wire       cnt_clear = wr_data1 && sel(ctrl_one_q, `IDX_CNT_CLEAR);
  wire       cnt_step  = wr_data1 && sel(ctrl_one_q, `IDX_CNT_STEP);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acq_setup_q   <= `BYTE_RESET;
      trig_src_q    <= `TSRC_CHAN_ONE;
      post_target_q <= 16'h0000;
      timebase_ctrl <= `BYTE_RESET;
      timer_data    <= `BYTE_RESET;
      timer_write   <= 1'b0;
    end else if (ce) begin
      timer_write <= 1'b0;
      if (wr_data1) begin
        case (ctrl_one_q[2:0])
          `IDX_POST_LO:     post_target_q[7:0]  <= host_wdata;
          `IDX_POST_HI:     post_target_q[15:8] <= host_wdata;
          `IDX_TIMEBASE:    timebase_ctrl       <= host_wdata;
          `IDX_ACQ_SETUP:   acq_setup_q         <= {2'b00, 2'b00, host_wdata[3:0]};
          `IDX_TIMER_LOAD: begin
            timer_data  <= host_wdata;
            timer_write <= 1'b1;
          end
          `IDX_TRIG_SOURCE: trig_src_q <= host_wdata[2:0];
          default: ;
        endcase
      end
    end
  end

  // Setup bits drive the clock and path controls
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_clk_run      <= 1'b0;
      sample_clk_internal <= 1'b0;
      live_data_path      <= 1'b0;
      conv_clk_on         <= 1'b0;
    end else if (ce) begin
      sample_clk_run      <= acq_setup_q[`ACQ_SCLK_RUN];
      sample_clk_internal <= acq_setup_q[`ACQ_SCLK_INT];
      live_data_path      <= acq_setup_q[`ACQ_LIVE_PATH];
      conv_clk_on         <= acq_setup_q[`ACQ_CONV_CLK_ON];
    end
  end

  // ========================================================================
  // Per-channel data registers and trigger logic
  reg  [7:0] thr_one_q  [0:1];
  reg  [7:0] thr_two_q  [0:1];
  reg  [3:0] sense_q    [0:1];
  reg  [1:0] gating_q   [0:1];
  reg  [6:0] serial_q   [0:1];
  reg        chan_trig_q [0:1];
  wire [1:0] wr_chan  = {wr_data3, wr_data2};
  wire [7:0] adc_raw  [0:1];
  wire [7:0] adc_gated [0:1];
  wire [1:0] chan_fire;
  assign adc_raw[0] = adc_one_data;
  assign adc_raw[1] = adc_two_data;

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_chan
      wire [7:0] cv = ctrl_chan_q[c];
      // Forced zero gating applies before comparison and storage
      assign adc_gated[c] = gating_q[c][0] ? adc_raw[c] : 8'h00;
      // Above/below result per threshold, sense bit selects polarity
      wire above1 = thr_one_q[c] > adc_gated[c];
      wire above2 = thr_two_q[c] > adc_gated[c];
      wire hit1   = sense_q[c][0] ? (thr_one_q[c] < adc_gated[c]) : above1;
      wire hit2   = sense_q[c][1] ? (thr_two_q[c] < adc_gated[c]) : above2;
      // Reserved combine codes never fire
      assign chan_fire[c] = (sense_q[c][3:2] == `CMB_AND) ? (hit1 & hit2) :
                            (sense_q[c][3:2] == `CMB_OR)  ? (hit1 | hit2) : 1'b0;
      wire tclr = wr_chan[c] && sel(cv, `IDX_TRIG_CLEAR);

      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          thr_one_q[c]   <= `BYTE_RESET;
          thr_two_q[c]   <= `BYTE_RESET;
          sense_q[c]     <= 4'h0;
          gating_q[c]    <= 2'h0;
          serial_q[c]    <= 7'h00;
          chan_trig_q[c] <= 1'b0;
        end else if (ce) begin
          if (wr_chan[c]) begin
            case (cv[2:0])
              `IDX_THRESH_ONE: thr_one_q[c] <= host_wdata;
              `IDX_THRESH_TWO: thr_two_q[c] <= host_wdata;
              `IDX_CMP_SENSE:  sense_q[c]   <= host_wdata[3:0];
              `IDX_SERIAL:     serial_q[c]  <= host_wdata[6:0];
              `IDX_GATING:     gating_q[c]  <= host_wdata[1:0];
              default: ;
            endcase
          end
          // Sticky trigger; a fire in the clear cycle wins
          if (sample_tick && chan_fire[c] && measure_active) begin
            chan_trig_q[c] <= 1'b1;
          end else if (tclr) begin
            chan_trig_q[c] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Serial pins and clock inversion registered straight to the ports
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_one_pins  <= 7'h00;
      serial_two_pins  <= 7'h00;
      conv_one_clk_inv <= 1'b0;
      conv_two_clk_inv <= 1'b0;
    end else if (ce) begin
      serial_one_pins  <= serial_q[0];
      serial_two_pins  <= serial_q[1];
      conv_one_clk_inv <= gating_q[0][1];
      conv_two_clk_inv <= gating_q[1][1];
    end
  end

  // ========================================================================
  // Trigger source selection
  reg trig_sel;
  always @* begin
    case (trig_src_q)
      `TSRC_CHAN_ONE:  trig_sel = chan_trig_q[0];
      `TSRC_CHAN_TWO:  trig_sel = chan_trig_q[1];
      `TSRC_IMMEDIATE: trig_sel = 1'b1;
      `TSRC_AND:       trig_sel = chan_trig_q[0] & chan_trig_q[1];
      `TSRC_OR:        trig_sel = chan_trig_q[0] | chan_trig_q[1];
      `TSRC_EXTERNAL:  trig_sel = ext_lvl_q;
      default:         trig_sel = 1'b0;
    endcase
  end

  // ========================================================================
  // Address counter plus post-trigger counter that ends the measurement
  wire [`ADDR_CNT_W-1:0] addr_cnt;
  reg  [15:0]            post_cnt_q;
  wire                   run_inc = sample_tick && sample_clk_run && live_data_path &&
                                   measure_active;

  scope_step_counter #(
    .W (`ADDR_CNT_W)
  ) u_addr_cnt (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .clear   (cnt_clear),
    .step    (cnt_step),
    .run_inc (run_inc),
    .count_q (addr_cnt)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      post_cnt_q     <= 16'h0000;
      measure_active <= 1'b0;
      trigger_out    <= 1'b0;
      mem_addr       <= {`ADDR_CNT_W{1'b0}};
    end else if (ce) begin
      mem_addr    <= addr_cnt;
      trigger_out <= trig_sel;
      if (cnt_clear) begin
        post_cnt_q     <= 16'h0000;
        measure_active <= 1'b1;     // Clear arms a fresh measurement
      end else if (run_inc && trig_sel) begin
        if (post_cnt_q == post_target_q) begin
          measure_active <= 1'b0;
        end else begin
          post_cnt_q <= post_cnt_q + 16'h0001;
        end
      end
    end
  end

  // Live samples feed memory writes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_one_wdata <= 8'h00;
      mem_two_wdata <= 8'h00;
    end else if (ce) begin
      mem_one_wdata <= adc_gated[0];
      mem_two_wdata <= adc_gated[1];
    end
  end

  // ========================================================================
  // Read mux; stored registers never read back, only counter, flag and sample data ports
  reg [7:0] rd_mux;
  always @* begin
    case (port_ofs)
      `OFS_CTRL1:  rd_mux = addr_cnt[7:0];
      `OFS_DATA1:  rd_mux = {1'b0, addr_cnt[14:8]};
      `OFS_FLAGS:  rd_mux = {5'h00, chan_trig_q[1], chan_trig_q[0],
                             conv_ready};
      `OFS_CTRL2:  rd_mux = live_data_path ? adc_gated[0] : mem_one_data;
      `OFS_CTRL3:  rd_mux = live_data_path ? adc_gated[1] : mem_two_data;
      default:     rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata    <= 8'h00;
      host_rdata_oe <= 1'b0;
    end else if (ce) begin
      host_rdata    <= rd_level ? rd_mux : 8'h00;
      host_rdata_oe <= rd_level;
    end
  end

endmodule // scope_io_regs

// *** rtl/scope_io_defs.vh ***
// Constants for the scope card host I/O register block.
// Included by the register block and its address counter; definitions only.
`ifndef SCOPE_IO_DEFS_VH
`define SCOPE_IO_DEFS_VH

// ==========================================================================
// Host port offsets (address lines 2..0)
`define OFS_CTRL1        3'h0
`define OFS_DATA1        3'h1
`define OFS_FLAGS        3'h2
`define OFS_UNUSED       3'h3
`define OFS_CTRL2        3'h4
`define OFS_DATA2        3'h5
`define OFS_CTRL3        3'h6
`define OFS_DATA3        3'h7

// ==========================================================================
// First control register indexes
`define IDX_POST_LO      3'h0
`define IDX_POST_HI      3'h1
`define IDX_TIMEBASE     3'h2
`define IDX_ACQ_SETUP    3'h3
`define IDX_CNT_CLEAR    3'h4
`define IDX_CNT_STEP     3'h5
`define IDX_TIMER_LOAD   3'h6
`define IDX_TRIG_SOURCE  3'h7

// ==========================================================================
// Channel control register indexes
`define IDX_THRESH_ONE   3'h0
`define IDX_THRESH_TWO   3'h1
`define IDX_CMP_SENSE    3'h2
`define IDX_SERIAL       3'h3
`define IDX_GATING       3'h4
`define IDX_TRIG_CLEAR   3'h5

// ==========================================================================
// Acquisition setup fields
`define ACQ_SCLK_RUN     0
`define ACQ_SCLK_INT     1
`define ACQ_LIVE_PATH    2
`define ACQ_CONV_CLK_ON  3

// ==========================================================================
// Trigger source codes
`define TSRC_CHAN_ONE    3'h0
`define TSRC_CHAN_TWO    3'h1
`define TSRC_IMMEDIATE   3'h2
`define TSRC_AND         3'h3
`define TSRC_OR          3'h4
`define TSRC_EXTERNAL    3'h5

// ==========================================================================
// Comparison sense combine codes (bits 3..2)
`define CMB_AND          2'h1
`define CMB_OR           2'h2

// ==========================================================================
// Widths and reset values
`define ADDR_CNT_W       15
`define POST_CNT_W       16
`define BYTE_RESET       8'h00
`define DEF_BASE_SWITCH  7'h60

`endif

// *** rtl/scope_step_counter.v ***
// Memory address counter with clear and single step.
// Assumes clear and step are one-cycle pulses from the same clock domain.
`include "scope_io_defs.vh"

module scope_step_counter #(
  parameter W = `ADDR_CNT_W
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         ce,
  input  wire         clear,
  input  wire         step,
  input  wire         run_inc,
  output reg  [W-1:0] count_q
);

  // ========================================================================
  // Counter; clear beats step so a clear is never undone
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= {W{1'b0}};
    end else if (ce) begin
      if (clear) begin
        count_q <= {W{1'b0}};
      end else if (step || run_inc) begin
        count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // scope_step_counter

// *** test/scope_host_model.sv ***
// Host bus master model: byte writes and reads on the eight card ports.
// Assumes one task call at a time and a free-running clk.
module scope_host_model (
  input  wire logic       clk,
  input  wire logic       host_rdata_oe,
  output logic      [9:0] host_addr,
  output logic      [7:0] host_wdata,
  output logic            host_iow_n,
  output logic            host_ior_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] base = 7'h2d;
  int         w;

  // ====================
  // Bus cycles
  // Strobes last ten clocks, well above the four the synchroniser needs
  initial begin
    host_addr  = 10'h000;
    host_wdata = 8'h00;
    host_iow_n = 1'b1;
    host_ior_n = 1'b1;
  end

  task automatic io_wr(input logic [2:0] ofs, input logic [7:0] data);
    @(negedge clk);
    host_addr  = {base, ofs};
    host_wdata = data;
    host_iow_n = 1'b0;
    repeat (10) @(negedge clk);
    host_iow_n = 1'b1;
    repeat (2) @(negedge clk);
    host_wdata = ~data; // Released bus shows no stale byte
    repeat (8) @(negedge clk);
  endtask

  // Index byte first, then the data port just above it
  task automatic io_sel(input logic [2:0] ctl, input logic [2:0] idx, input logic [7:0] data);
    io_wr(ctl, {5'h00, idx});
    io_wr(ctl + 3'h1, data);
  endtask

  task automatic io_rd(input logic [2:0] ofs);
    @(negedge clk);
    host_addr  = {base, ofs};
    host_ior_n = 1'b0;
    repeat (10) @(negedge clk);
    host_ior_n = 1'b1;
    for (w = 0; w < 16 && host_rdata_oe === 1'b1; w++) @(negedge clk);
    repeat (4) @(negedge clk);
  endtask
endmodule // scope_host_model

// *** test/scope_io_regs_asserts.sv ***
// Port assertions for the scope card host I/O register block.
// Assumes host strobes of at least four clocks with a stable address.
`include "scope_io_defs.vh"

module scope_io_regs_asserts #(
  parameter BASE_SW_W = 7
) (
  input wire                   clk,
  input wire                   rst_n,
  input wire [9:0]             host_addr,
  input wire                   host_ior_n,
  input wire [BASE_SW_W-1:0]   base_select_switch,
  input wire [7:0]             host_rdata,
  input wire                   host_rdata_oe,
  input wire                   timer_write,
  input wire [`ADDR_CNT_W-1:0] mem_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  wire [6:0] addr_hi = host_addr[9:3];

  // ====================
  // Read port and pulses
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_read_done;
    host_ior_n [*8];
  endsequence
  sequence s_addr_still;
    ($stable(mem_addr)) [*3];
  endsequence
  property p_rdata_idle;
    !host_rdata_oe |-> host_rdata == 8'h00;
  endproperty
  property p_oe_launch;
    $rose(host_rdata_oe) |-> $past(host_ior_n, 3) == 1'b0;
  endproperty
  property p_oe_release;
    s_read_done |-> !host_rdata_oe;
  endproperty
  property p_base_match;
    $rose(host_rdata_oe) |-> $past(addr_hi, 3) == $past(base_select_switch, 3);
  endproperty
  property p_timer_pulse;
    timer_write |=> !timer_write;
  endproperty
  // Counter only ever steps by one or returns to zero
  property p_addr_step;
    $changed(mem_addr) |-> mem_addr == $past(mem_addr) + 1'b1 || mem_addr == 0;
  endproperty
  property p_unused_zero;
    host_rdata_oe && host_addr[2:0] == `OFS_UNUSED |-> host_rdata == 8'h00;
  endproperty
  property p_flags_zero;
    host_rdata_oe && host_addr[2:0] == `OFS_FLAGS |-> host_rdata[7:3] == 5'h00;
  endproperty
  property p_hi_bit7;
    host_rdata_oe && host_addr[2:0] == `OFS_DATA1 |-> !host_rdata[7];
  endproperty
  property p_lo_counter;
    s_addr_still ##0 (host_rdata_oe && host_addr[2:0] == `OFS_CTRL1)
      |-> host_rdata == mem_addr[7:0];
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero");
  a_oe_launch: assert property (p_oe_launch) else $error("oe without read");
  a_oe_release: assert property (p_oe_release) else $error("oe held");
  a_base_match: assert property (p_base_match) else $error("wrong base");
  a_timer_pulse: assert property (p_timer_pulse) else $error("timer pulse long");
  a_addr_step: assert property (p_addr_step) else $error("counter jump");
  a_unused_zero: assert property (p_unused_zero) else $error("unused not zero");
  a_flags_zero: assert property (p_flags_zero) else $error("flag bits set");
  a_hi_bit7: assert property (p_hi_bit7) else $error("hi bit7 set");
  a_lo_counter: assert property (p_lo_counter) else $error("counter low bad");
endmodule // scope_io_regs_asserts

bind scope_io_regs scope_io_regs_asserts #(.BASE_SW_W(BASE_SW_W)) u_scope_io_regs_asserts (
  .clk(clk), .rst_n(rst_n), .host_addr(host_addr), .host_ior_n(host_ior_n),
  .base_select_switch(base_select_switch), .host_rdata(host_rdata),
  .host_rdata_oe(host_rdata_oe), .timer_write(timer_write), .mem_addr(mem_addr));

// *** test/scope_io_regs_tb.sv ***
// Self-checking bench for the scope card host I/O register block.
// Assumes the host model owns the bus; the bench drives the other inputs.
`include "scope_io_defs.vh"
`define CHK(nm, e, s) begin cmp_count++; if ((e) !== (s)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", nm, e, s); end end

module scope_io_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   ce = 1'b1;
  logic                   conv_ready = 1'b1;
  logic                   ext_trigger = 1'b1;
  logic                   sample_tick = 1'b0;
  logic [6:0]             base_select_switch = 7'h2d;
  logic [7:0]             adc_one_data = 8'h5a, adc_two_data = 8'hc3, e, r;
  logic [7:0]             mem_one_data = 8'h3c, mem_two_data = 8'ha5;
  logic [9:0]             host_addr;
  logic [7:0]             host_wdata, host_rdata, timer_data, timebase_ctrl;
  logic [7:0]             mem_one_wdata, mem_two_wdata;
  logic                   host_iow_n, host_ior_n, host_rdata_oe, sample_clk_run;
  logic                   sample_clk_internal, live_data_path, conv_clk_on, timer_write;
  logic                   measure_active, trigger_out, conv_one_clk_inv, conv_two_clk_inv;
  logic [`ADDR_CNT_W-1:0] mem_addr;
  logic [6:0]             serial_one_pins, serial_two_pins;
  logic [7:0]             exp_q[$];
  logic [7:0]             rd_exp[4] = '{8'h03, 8'h00, 8'h01, 8'h00};
  logic [5:0]             src_exp = 6'b110101;
  int                     err_total = 0, cmp_count = 0, cyc = 0, i;
  int                     seed = 32'h5fb8;
  wire  [3:0]             setup = {conv_clk_on, live_data_path, sample_clk_internal, sample_clk_run};

  // ====================
  // Design, host and clock
  scope_io_regs u_scope_io_regs (
    .clk(clk), .rst_n(rst_n), .ce(ce), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_iow_n(host_iow_n), .host_ior_n(host_ior_n), .base_select_switch(base_select_switch),
    .adc_one_data(adc_one_data), .adc_two_data(adc_two_data), .mem_one_data(mem_one_data),
    .mem_two_data(mem_two_data), .conv_ready(conv_ready), .ext_trigger(ext_trigger),
    .sample_tick(sample_tick), .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe),
    .sample_clk_run(sample_clk_run), .sample_clk_internal(sample_clk_internal),
    .live_data_path(live_data_path), .conv_clk_on(conv_clk_on), .timer_data(timer_data),
    .timer_write(timer_write), .timebase_ctrl(timebase_ctrl), .mem_one_wdata(mem_one_wdata),
    .mem_two_wdata(mem_two_wdata), .mem_addr(mem_addr), .measure_active(measure_active),
    .trigger_out(trigger_out), .serial_one_pins(serial_one_pins),
    .serial_two_pins(serial_two_pins), .conv_one_clk_inv(conv_one_clk_inv),
    .conv_two_clk_inv(conv_two_clk_inv));
  scope_host_model u_host (
    .clk(clk), .host_rdata_oe(host_rdata_oe), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_iow_n(host_iow_n), .host_ior_n(host_ior_n));
  always #2.5 clk = ~clk;

  // Hang guard, generous against some 1700 cycles of traffic
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  // Read watcher: oldest note against the driven byte; empty queue reads as unknown
  always @(posedge host_rdata_oe) begin
    repeat (2) @(negedge clk);
    if (exp_q.size() == 0) e = 8'hxx;
    else e = exp_q.pop_front();
    `CHK("host_rdata", e, host_rdata)
  end

  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk);
      sample_tick = 1'b1;
      @(negedge clk);
      sample_tick = 1'b0;
    end
  endtask

  // ====================
  // Scenarios
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    for (i = 0; i < 4; i++) begin
      u_host.io_sel(`OFS_CTRL1, `IDX_ACQ_SETUP, 8'h01 << i);
      `CHK("setup", setup, 4'h1 << i)
    end
    u_host.io_wr(`OFS_DATA1, 8'h0f);
    `CHK("setup", setup, 4'hf)
    // Clock enable low: the strobe is never seen, so the write is lost
    ce = 1'b0;
    u_host.io_wr(`OFS_DATA1, 8'h00);
    ce = 1'b1;
    `CHK("setup", setup, 4'hf)
    // Foreign base: write and read must both be ignored
    u_host.base = 7'h2c;
    u_host.io_wr(`OFS_DATA1, 8'h00);
    u_host.io_rd(`OFS_FLAGS);
    u_host.base = 7'h2d;
    `CHK("setup", setup, 4'hf)
    u_host.io_sel(`OFS_CTRL2, `IDX_GATING, 8'h03);
    u_host.io_sel(`OFS_CTRL3, `IDX_GATING, 8'h01);
    `CHK("clk_inv", {conv_one_clk_inv, conv_two_clk_inv}, 2'b10)
    {adc_one_data, adc_two_data, mem_one_data, mem_two_data} = $random(seed);
    exp_q.push_back(adc_one_data);
    u_host.io_rd(`OFS_CTRL2);
    exp_q.push_back(adc_two_data);
    u_host.io_rd(`OFS_CTRL3);
    u_host.io_wr(`OFS_DATA3, 8'h00);
    `CHK("mem_wdata", {mem_one_wdata, mem_two_wdata}, {adc_one_data, 8'h00})
    u_host.io_wr(`OFS_DATA1, 8'h0b);
    exp_q.push_back(mem_one_data);
    u_host.io_rd(`OFS_CTRL2);
    exp_q.push_back(mem_two_data);
    u_host.io_rd(`OFS_CTRL3);
    r = 8'($random(seed));
    u_host.io_sel(`OFS_CTRL2, `IDX_SERIAL, {1'b0, r[6:0]});
    u_host.io_sel(`OFS_CTRL3, `IDX_SERIAL, {1'b0, ~r[6:0]});
    u_host.io_sel(`OFS_CTRL2, 3'h6, 8'h00);
    `CHK("serial", {serial_one_pins, serial_two_pins}, {r[6:0], ~r[6:0]})
    u_host.io_sel(`OFS_CTRL1, `IDX_TIMER_LOAD, r);
    `CHK("timer_data", timer_data, r)
    u_host.io_sel(`OFS_CTRL1, `IDX_TIMEBASE, ~r);
    `CHK("timebase", timebase_ctrl, ~r)
    u_host.io_sel(`OFS_CTRL1, `IDX_POST_LO, 8'hff);
    u_host.io_sel(`OFS_CTRL1, `IDX_POST_HI, 8'hff);
    u_host.io_sel(`OFS_CTRL1, `IDX_CNT_CLEAR, ~r);
    `CHK("count", {measure_active, mem_addr}, 16'h8000)
    u_host.io_sel(`OFS_CTRL1, `IDX_CNT_STEP, r);
    u_host.io_wr(`OFS_DATA1, ~r);
    u_host.io_wr(`OFS_DATA1, 8'h00);
    `CHK("count", mem_addr, 15'h0003)
    for (i = 0; i < 4; i++) begin
      exp_q.push_back(rd_exp[i]);
      u_host.io_rd(3'(i));
    end
    // Both thresholds above the sample, combined by AND
    u_host.io_sel(`OFS_CTRL2, `IDX_THRESH_ONE, 8'h80);
    u_host.io_sel(`OFS_CTRL2, `IDX_THRESH_TWO, 8'h80);
    u_host.io_sel(`OFS_CTRL2, `IDX_CMP_SENSE, 8'h04);
    adc_one_data = 8'h10;
    tick(4);
    exp_q.push_back(8'h03);
    u_host.io_rd(`OFS_FLAGS);
    for (i = 0; i < 6; i++) begin
      u_host.io_sel(`OFS_CTRL1, `IDX_TRIG_SOURCE, {5'h00, 3'(i)});
      `CHK("trigger_out", trigger_out, src_exp[i])
    end
    // External pin low must drop the selected trigger after the synchroniser
    ext_trigger = 1'b0;
    repeat (8) @(negedge clk);
    `CHK("trigger_out", trigger_out, 1'b0)
    adc_one_data = 8'h90;
    u_host.io_sel(`OFS_CTRL2, `IDX_TRIG_CLEAR, r);
    tick(2);
    exp_q.push_back(8'h01);
    u_host.io_rd(`OFS_FLAGS);
    // Post count needs live samples and a fired channel one
    u_host.io_sel(`OFS_CTRL1, `IDX_TRIG_SOURCE, 8'h00);
    u_host.io_sel(`OFS_CTRL1, `IDX_ACQ_SETUP, 8'h0f);
    u_host.io_sel(`OFS_CTRL1, `IDX_POST_LO, 8'h03);
    u_host.io_sel(`OFS_CTRL1, `IDX_POST_HI, 8'h00);
    u_host.io_sel(`OFS_CTRL1, `IDX_CNT_CLEAR, r);
    adc_one_data = 8'h10;
    tick(12);
    `CHK("measure", measure_active, 1'b0)
    `CHK("trigger_out", trigger_out, 1'b1)
    `CHK("pending", exp_q.size(), 0)
    print_verdict();
  end
endmodule // scope_io_regs_tb
